// ### hdl/amc_defs.svh
// Functional notes
// - mode field codes: 00 run, 01 full power down, 10 standby, 11 digital reset.
// - test register low four bits pick a test pattern; nonzero replaces conversion data.
// - 0000 off by default, 0001 midscale, 0010 positive full scale, 0011 negative.
// - 0100 gives a checkerboard alternating between complementary words.
// - 0101 gives a 23-bit pseudorandom sequence, 0110 a 9-bit one.
// - 0111 toggles whole words ones/zeros; 1001 gives a one/zero bit toggle.
// - 1000 user pattern, 1010 sync, 1011 one bit high, 1100 mixed frequency.
// - host sets self-test bit 0; device starts self-test whenever it is set.
// - an eight-bit twos complement offset, +127 to -128, adds to conversion output.
`ifndef AMC_DEFS_SVH
`define AMC_DEFS_SVH
`define AMC_OFS_MODES     8'h08
`define AMC_OFS_CLKDIV    8'h0b
`define AMC_OFS_TEST      8'h0d
`define AMC_OFS_SELFTEST  8'h0e
`define AMC_OFS_OFFSET    8'h10
`define AMC_OFS_OUTFMT    8'h14
`define AMC_RST_VALUE     8'h00
`define AMC_BIT_INVERT    2
`define AMC_BIT_DISABLE   4
`define AMC_BIT_ST_INIT   2
`define AMC_USER_PATTERN  12'ha5c
`define AMC_SYNC_PATTERN  12'h800
`define AMC_PN23_SEED     23'h7fffff
`define AMC_PN9_SEED      9'h1ff
`endif

// ### hdl/amc_pkg.sv
package amc_pkg;
    typedef enum logic [1:0] {AMC_RUN, AMC_PDOWN, AMC_STBY, AMC_DRST} amc_mode_t;
    typedef enum logic [1:0] {AMC_OFFBIN, AMC_TWOS, AMC_GRAY, AMC_OFFBIN2} amc_fmt_t;
endpackage : amc_pkg

// ### hdl/amc_regs.sv
`timescale 1ns/1ps
`include "amc_defs.svh"
module amc_regs
    import amc_pkg::*;
#(
    parameter int DW = 12
)(
    // clock, reset, enable
    input  wire logic          clk,
    input  wire logic          arst_n,
    input  wire logic          ce,
    // register port
    input  wire logic          reg_wr,
    input  wire logic [7:0]    reg_addr,
    input  wire logic [7:0]    reg_wdata,
    output logic      [7:0]    reg_rdata_q,
    // conversion data in, pattern data out
    input  wire logic [DW-1:0] conv_data,
    output logic      [DW-1:0] dout_q,
    output logic               dout_oe_q,
    // mode controls
    output logic               run_q,
    output logic               power_down_q,
    output logic               standby_q,
    output logic               digital_reset_q,
    output logic               self_test_start_q,
    output logic               clk_div_pulse_q
);
    logic [7:0] modes_q, modes_d, div_q, div_d, test_q, test_d;
    logic [7:0] st_q, st_d, ofs_q, ofs_d, fmt_q, fmt_d, rd_d;
    logic [2:0] cnt_q, cnt_d;
    logic [22:0] pn23_q, pn23_d;
    logic [8:0]  pn9_q, pn9_d;
    logic        tog_q, tog_d;
    logic [3:0]  bit_q, bit_d;
    logic [DW-1:0] pat, corr, fm, dout_d;
    logic [DW:0]   sum;
    logic          run_d, power_down_d, standby_d, digital_reset_d;
    logic          self_test_start_d, clk_div_pulse_d, dout_oe_d;

    // register writes and read mux
    always_comb
    begin
        modes_d = modes_q;
        div_d   = div_q;
        test_d  = test_q;
        st_d    = st_q;
        ofs_d   = ofs_q;
        fmt_d   = fmt_q;
        if (reg_wr)
        begin
            case (reg_addr)
                `AMC_OFS_MODES:    modes_d = reg_wdata;
                `AMC_OFS_CLKDIV:   div_d   = reg_wdata;
                `AMC_OFS_TEST:     test_d  = reg_wdata;
                `AMC_OFS_SELFTEST: st_d    = reg_wdata;
                `AMC_OFS_OFFSET:   ofs_d   = reg_wdata;
                `AMC_OFS_OUTFMT:   fmt_d   = reg_wdata;
                default: ;
            endcase
        end
        case (reg_addr)
            `AMC_OFS_MODES:    rd_d = modes_q;
            `AMC_OFS_CLKDIV:   rd_d = div_q;
            `AMC_OFS_TEST:     rd_d = test_q;
            `AMC_OFS_SELFTEST: rd_d = st_q;
            `AMC_OFS_OFFSET:   rd_d = ofs_q;
            `AMC_OFS_OUTFMT:   rd_d = fmt_q;
            default:           rd_d = 8'h00; // unmapped reads as zero
        endcase
    end

    // divider, pattern generators and data path next state
    always_comb
    begin
        // ratio is field plus one, so count 0..field
        cnt_d  = (cnt_q >= div_q[2:0]) ? 3'h0 : cnt_q + 3'h1;
        clk_div_pulse_d = (cnt_q == 3'h0);
        pn23_d = {pn23_q[21:0], pn23_q[22] ^ pn23_q[17]};
        pn9_d  = {pn9_q[7:0], pn9_q[8] ^ pn9_q[4]};
        // generators restart while their reset bits are set, so a test can realign
        if (test_q[5])
            pn23_d = `AMC_PN23_SEED;
        if (test_q[4])
            pn9_d  = `AMC_PN9_SEED;
        tog_d  = ~tog_q;
        bit_d  = (bit_q == 4'(DW - 1)) ? 4'h0 : bit_q + 4'h1;
        case (test_q[3:0])
            4'h1:    pat = {1'b1, {(DW-1){1'b0}}};
            4'h2:    pat = {1'b1, {(DW-1){1'b1}}};
            4'h3:    pat = {DW{1'b0}};
            4'h4:    pat = tog_q ? {(DW/2){2'b10}} : {(DW/2){2'b01}};
            4'h5:    pat = pn23_q[DW-1:0];
            4'h6:    pat = {pn9_q, pn9_q[8:6]};
            4'h7:    pat = {DW{tog_q}};
            4'h8:    pat = `AMC_USER_PATTERN;
            4'h9:    pat = tog_q ? {(DW/2){2'b10}} : {DW{1'b0}};
            4'ha:    pat = `AMC_SYNC_PATTERN;
            4'hb:    pat = DW'(1) << bit_q;
            4'hc:    pat = {{(DW/4){tog_q}}, {(DW/4){1'b1}}, {(DW/4){1'b0}},
                            {(DW/4){cnt_q[0]}}};
            default: pat = '0;
        endcase
        // offset added in signed domain, saturating
        sum  = {conv_data[DW-1], conv_data} + {{(DW-7){ofs_q[7]}}, ofs_q};
        if (sum[DW] != sum[DW-1])
            corr = sum[DW] ? {1'b1, {(DW-1){1'b0}}} : {1'b0, {(DW-1){1'b1}}};
        else
            corr = sum[DW-1:0];
        // format conversion on offset-binary code; core data is twos complement
        fm = (test_q[3:0] != 4'h0) ? pat : {~corr[DW-1], corr[DW-2:0]};
        case (amc_fmt_t'(fmt_q[1:0]))
            AMC_TWOS: fm = {~fm[DW-1], fm[DW-2:0]};
            AMC_GRAY: fm = fm ^ (fm >> 1);
            default:  fm = fm;
        endcase
        dout_d = fmt_q[`AMC_BIT_INVERT] ? ~fm : fm;
        dout_oe_d = ~fmt_q[`AMC_BIT_DISABLE];
        // one-hot mode decode; digital reset is only flagged, registers keep their values
        run_d             = (modes_q[1:0] == AMC_RUN);
        power_down_d      = (modes_q[1:0] == AMC_PDOWN);
        standby_d         = (modes_q[1:0] == AMC_STBY);
        digital_reset_d   = (modes_q[1:0] == AMC_DRST);
        self_test_start_d = st_q[0];
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            modes_q <= `AMC_RST_VALUE;
            div_q   <= `AMC_RST_VALUE;
            test_q  <= `AMC_RST_VALUE;
            st_q    <= `AMC_RST_VALUE;
            ofs_q   <= `AMC_RST_VALUE;
            fmt_q   <= `AMC_RST_VALUE;
            reg_rdata_q <= 8'h00;
            cnt_q   <= 3'h0;
            pn23_q  <= `AMC_PN23_SEED;
            pn9_q   <= `AMC_PN9_SEED;
            tog_q   <= 1'b0;
            bit_q   <= 4'h0;
            dout_q  <= '0;
            dout_oe_q <= 1'b0;
            run_q <= 1'b0;
            power_down_q <= 1'b0;
            standby_q <= 1'b0;
            digital_reset_q <= 1'b0;
            self_test_start_q <= 1'b0;
            clk_div_pulse_q <= 1'b0;
        end
        else if (ce)
        begin
            modes_q <= modes_d;
            div_q   <= div_d;
            test_q  <= test_d;
            st_q    <= st_d;
            ofs_q   <= ofs_d;
            fmt_q   <= fmt_d;
            reg_rdata_q <= rd_d;
            cnt_q   <= cnt_d;
            pn23_q  <= pn23_d;
            pn9_q   <= pn9_d;
            tog_q   <= tog_d;
            bit_q   <= bit_d;
            dout_q  <= dout_d;
            dout_oe_q         <= dout_oe_d;
            run_q             <= run_d;
            power_down_q      <= power_down_d;
            standby_q         <= standby_d;
            digital_reset_q   <= digital_reset_d;
            self_test_start_q <= self_test_start_d;
            clk_div_pulse_q   <= clk_div_pulse_d;
        end
    end

    // each check looks one clock edge after its cause
    AST_MODE_RUN: assert property (@(posedge clk) disable iff (!arst_n)
        ce && modes_q[1:0] == 2'b00 |=> run_q && !power_down_q)
        else $error("run mode not decoded");
    AST_MODE_RST: assert property (@(posedge clk) disable iff (!arst_n)
        ce && modes_q[1:0] == 2'b11 |=> digital_reset_q && !standby_q)
        else $error("digital reset not decoded");
    AST_MODE_STBY: assert property (@(posedge clk) disable iff (!arst_n)
        ce && modes_q[1:0] == 2'b10 |=> standby_q && !run_q)
        else $error("standby mode not decoded");
    AST_MODE_PDN: assert property (@(posedge clk) disable iff (!arst_n)
        ce && modes_q[1:0] == 2'b01 |=> power_down_q && !digital_reset_q)
        else $error("power down mode not decoded");
    AST_TEST_MID: assert property (@(posedge clk) disable iff (!arst_n)
        ce && test_q[3:0] == 4'h1 && fmt_q[2:0] == 3'h0
        |=> dout_q == {1'b1, {(DW-1){1'b0}}})
        else $error("midscale pattern wrong");
    AST_TEST_NEG: assert property (@(posedge clk) disable iff (!arst_n)
        ce && test_q[3:0] == 4'h3 && fmt_q[2:0] == 3'h0 |=> dout_q == '0)
        else $error("negative full scale wrong");
    AST_CHECKER: assert property (@(posedge clk) disable iff (!arst_n)
        ce && test_q[3:0] == 4'h4 && fmt_q[2:0] == 3'h0 ##1 ce && test_q[3:0] == 4'h4
        && fmt_q[2:0] == 3'h0 |=> dout_q == ~$past(dout_q))
        else $error("checkerboard not alternating");
    AST_PN_HOLD: assert property (@(posedge clk) disable iff (!arst_n)
        ce && test_q[5] ##1 ce && test_q[5] && test_q[3:0] == 4'h5 && fmt_q[2:0] == 3'h0
        |=> dout_q == DW'(`AMC_PN23_SEED))
        else $error("long sequence did not restart");
    AST_WORD_TOG: assert property (@(posedge clk) disable iff (!arst_n)
        ce && test_q[3:0] == 4'h7 && fmt_q[2:0] == 3'h0
        |=> dout_q == '0 || dout_q == '1)
        else $error("word toggle not all ones or zeros");
    AST_ONE_HIGH: assert property (@(posedge clk) disable iff (!arst_n)
        ce && test_q[3:0] == 4'hb && fmt_q[2:0] == 3'h0 |=> $onehot(dout_q))
        else $error("one bit high pattern wrong");
    AST_SELFTEST: assert property (@(posedge clk) disable iff (!arst_n)
        ce && st_q[0] |=> self_test_start_q)
        else $error("self-test not started");
    // the counter only sits at zero once the ratio was already one an edge before
    AST_DIV1: assert property (@(posedge clk) disable iff (!arst_n)
        ce && div_q[2:0] == 3'h0 && $past(ce) && $past(div_q[2:0]) == 3'h0
        |=> clk_div_pulse_q)
        else $error("divide by one not continuous");
    AST_OFFSET: assert property (@(posedge clk) disable iff (!arst_n)
        ce && test_q[3:0] == 4'h0 && fmt_q[2:0] == 3'h1 && ofs_q == 8'h00
        |=> dout_q == $past(conv_data))
        else $error("zero offset changed data");
    AST_DISABLE: assert property (@(posedge clk) disable iff (!arst_n)
        ce && fmt_q[`AMC_BIT_DISABLE] |=> !dout_oe_q)
        else $error("output not disabled");
    // a low enable must hold the data, read-back and divider pulse outputs
    AST_FREEZE: assert property (@(posedge clk) disable iff (!arst_n)
        !ce |=> $stable(dout_q) && $stable(reg_rdata_q) && $stable(clk_div_pulse_q))
        else $error("state moved while enable low");
endmodule : amc_regs

// ### verification/amc_host.sv
`timescale 1ns/1ps
// host end of the register port; it changes its lines on the falling edge only
module amc_host (
    // clock
    input  wire logic       clk,
    // register port
    output logic            reg_wr,
    output logic [7:0]      reg_addr,
    output logic [7:0]      reg_wdata,
    input  wire logic [7:0] reg_rdata_q
);
    initial
    begin
        reg_wr    = 1'b0;
        reg_addr  = 8'h00;
        reg_wdata = 8'h00;
    end
    // one strobe cycle; stale data is inverted so a missed sample shows
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(negedge clk);
        reg_wr    <= 1'b0;
        reg_wdata <= ~d;
    endtask : wr
    // read data is registered, so it is taken one edge after the address
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        reg_addr <= a;
        @(negedge clk);
        d = reg_rdata_q;
    endtask : rd
endmodule : amc_host

// ### verification/tb_adc_mode_test_control_regs.sv
`timescale 1ns/1ps
`include "amc_defs.svh"
module tb_adc_mode_test_control_regs;
    logic        clk, arst_n, ce, reg_wr, oe, run, pd, sb, dr, st, dp;
    logic [7:0]  addr, wdata, rdata, r;
    logic [11:0] conv_data, dout, prev;
    int          bad_count = 0, cmp_count = 0, n;
    logic [7:0]  ofs [6] = '{8'h08, 8'h0b, 8'h0d, 8'h0e, 8'h10, 8'h14};
    logic [7:0]  val [6] = '{8'h01, 8'h03, 8'h0c, 8'h01, 8'h7f, 8'h13};
    logic [3:0]  tcode [6] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h8, 4'ha};
    logic [11:0] texp [6] = '{12'h923, 12'h800, 12'hfff, 12'h000, 12'ha5c, 12'h800};
    // clock enable is dropped once in mid-run to check that the data output freezes
    amc_regs #(.DW(12)) DUT (.clk(clk), .arst_n(arst_n), .ce(ce), .reg_wr(reg_wr),
        .reg_addr(addr), .reg_wdata(wdata), .reg_rdata_q(rdata), .conv_data(conv_data),
        .dout_q(dout), .dout_oe_q(oe), .run_q(run), .power_down_q(pd), .standby_q(sb),
        .digital_reset_q(dr), .self_test_start_q(st), .clk_div_pulse_q(dp));
    amc_host host (.clk(clk), .reg_wr(reg_wr), .reg_addr(addr), .reg_wdata(wdata),
        .reg_rdata_q(rdata));
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] g);
        cmp_count++;
        if (g !== e)
        begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // write, then let the decoded outputs and the data path catch up
    task automatic put(input logic [7:0] a, input logic [7:0] d);
        host.wr(a, d);
        repeat (2) @(negedge clk);
    endtask : put
    task automatic test_done();
        if (bad_count == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : test_done
    // watchdog far beyond the few hundred cycles the sequence needs
    initial
    begin
        #200000;
        bad_count++;
        test_done();
    end
    initial
    begin
        arst_n = 1'b0;
        ce = 1'b1;
        conv_data = 12'h123;
        repeat (5) @(negedge clk);
        arst_n = 1'b1;
        repeat (2) @(negedge clk);
        chk("modes", 12'h8, {run, pd, sb, dr});
        for (int i = 0; i < 6; i++)
        begin
            host.rd(ofs[i], r);
            chk("reset", 12'h0, r);
            host.wr(ofs[i], val[i]);
            host.rd(ofs[i], r);
            chk("readback", val[i], r);
            host.wr(ofs[i], (i == 5) ? 8'h01 : 8'h00);
        end
        host.wr(8'h20, 8'hff);
        host.rd(8'h20, r);
        chk("unmapped", 12'h0, r);
        for (int m = 0; m < 4; m++)
        begin
            put(`AMC_OFS_MODES, m[7:0]);
            chk("modes", 12'h8 >> m, {run, pd, sb, dr});
        end
        put(`AMC_OFS_MODES, 8'h00);
        put(`AMC_OFS_OUTFMT, 8'h01);
        put(`AMC_OFS_SELFTEST, 8'h01);
        chk("selftest", 12'h1, st);
        put(`AMC_OFS_SELFTEST, 8'h00);
        chk("selftest", 12'h0, st);
        for (int d = 0; d < 4; d++)
        begin
            // codes 0, 1, 3 and 7: ratios 1, 2, 4 and 8 over an 8-cycle window
            put(`AMC_OFS_CLKDIV, (8'h01 << d) - 8'h01);
            n = 0;
            repeat (8) @(negedge clk) n += dp;
            chk("divpulses", 12'd8 >> d, n[11:0]);
        end
        // offset binary with no inversion, so pattern words show as generated
        put(`AMC_OFS_OUTFMT, 8'h00);
        for (int i = 0; i < 6; i++)
        begin
            put(`AMC_OFS_TEST, {4'h0, tcode[i]});
            chk("pattern", texp[i], dout);
        end
        for (int c = 4; c < 8; c += 3)
        begin
            put(`AMC_OFS_TEST, c[7:0]);
            repeat (4)
            begin
                prev = dout;
                @(negedge clk);
                chk("alternate", ~prev, dout);
                if (c == 7)
                    chk("wordtoggle", {12{dout[0]}}, dout);
            end
        end
        put(`AMC_OFS_TEST, 8'h0b);
        chk("onehigh", 12'h1, 12'($countones(dout)));
        // long generator held at its seed, then one shift of x^23+x^18+1
        put(`AMC_OFS_TEST, 8'h25);
        chk("pnhold", 12'hfff, dout);
        put(`AMC_OFS_TEST, 8'h05);
        chk("pnrun", 12'hffe, dout);
        put(`AMC_OFS_TEST, 8'h16);
        chk("pnhold", 12'hfff, dout);
        put(`AMC_OFS_TEST, 8'h09);
        prev = dout;
        @(negedge clk);
        chk("bittoggle", 12'h000, dout & prev);
        // enable low: the toggling word must stand still
        prev = dout;
        ce = 1'b0;
        repeat (3) @(negedge clk);
        chk("freeze", prev, dout);
        ce = 1'b1;
        put(`AMC_OFS_OUTFMT, 8'h01);
        put(`AMC_OFS_TEST, 8'h00);
        put(`AMC_OFS_OFFSET, 8'h03);
        chk("offset", 12'h126, dout);
        put(`AMC_OFS_OFFSET, 8'h80);
        chk("offset", 12'h0a3, dout);
        conv_data = 12'h7fe;
        put(`AMC_OFS_OFFSET, 8'h7f);
        chk("offset", 12'h7ff, dout);
        conv_data = 12'h123;
        put(`AMC_OFS_OFFSET, 8'h00);
        put(`AMC_OFS_OUTFMT, 8'h00);
        chk("offbin", 12'h923, dout);
        put(`AMC_OFS_OUTFMT, 8'h03);
        chk("offbin", 12'h923, dout);
        put(`AMC_OFS_OUTFMT, 8'h02);
        chk("gray", 12'hdb2, dout);
        put(`AMC_OFS_OUTFMT, 8'h05);
        chk("invert", 12'hedc, dout);
        put(`AMC_OFS_OUTFMT, 8'h11);
        chk("disable", 12'h0, oe);
        // second reset in mid-run brings every register back to its default
        arst_n = 1'b0;
        @(negedge clk);
        arst_n = 1'b1;
        host.rd(`AMC_OFS_TEST, r);
        chk("rearm", 12'h0, r);
        chk("enable", 12'h1, oe);
        chk("modes", 12'h8, {run, pd, sb, dr});
        test_done();
    end
endmodule : tb_adc_mode_test_control_regs
